//--- design/acsc_capture.sv
// Converter readout glue: start resync, ready combine, shift clock relay, lane capture.
// Summary of operation
// - One shared system clock times everything.
// - Conversion start passes a flop per converter.
// - Ready strobes are ANDed into one indication.
// - Host shift clock is regenerated toward converters.
// - Sample lanes on both forwarded clock edges.
// - Invert data bits, never the clock lane.
// - Eighteen bits shifted form one sample.
`timescale 1ns/1ps
`default_nettype none
`include "acsc_params.svh"

module acsc_capture
    import acsc_pkg::*;
#(
    parameter int N_CONV    = `ACSC_N_CONV,
    parameter int LANES     = `ACSC_LANES,
    parameter int WORD_BITS = `ACSC_WORD_BITS
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 conv_start_in,
    input  wire logic [N_CONV-1:0]    converter_ready_strobe,
    input  wire logic                 host_shift_clk,
    input  wire logic                 fwd_clk,
    input  wire logic [LANES-1:0]     lane_data,
    output logic      [N_CONV-1:0]    conv_start_out,
    output logic                      host_ready,
    output logic                      conv_shift_clk,
    output logic      [WORD_BITS-1:0] sample_data,
    output logic                      sample_valid,
    output logic                      frame_aligned
);

    localparam int SYNC_W = `ACSC_SYNC_READY + N_CONV + LANES;
    localparam int LANE_LO = `ACSC_SYNC_READY + N_CONV;
    localparam logic [`ACSC_CNT_W-1:0] LAST_BIT = `ACSC_CNT_W'(WORD_BITS - 1);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second stage.

    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic              fwd_prev;
    logic              ready_all_prev;
    logic [SYNC_W-1:0] next_sync1;
    logic [SYNC_W-1:0] next_sync2;
    logic              next_fwd_prev;
    logic              next_ready_all_prev;

    logic              start_s;
    logic              shift_s;
    logic              fwd_s;
    logic [N_CONV-1:0] ready_s;
    logic [LANES-1:0]  lanes_s;
    logic              ready_all;
    logic              link_edge;
    logic              frame_start;

    assign start_s     = sync2[`ACSC_SYNC_START];
    assign shift_s     = sync2[`ACSC_SYNC_SHIFT];
    // The clock lane is used as is; only the capture lane bit is taken inverted, into rx_bit.
    assign fwd_s       = sync2[`ACSC_SYNC_FWD];
    assign ready_s     = sync2[`ACSC_SYNC_READY +: N_CONV];
    assign lanes_s     = sync2[LANE_LO +: LANES];
    assign ready_all   = &ready_s;
    // Either edge of the forwarded clock marks a bit slot, giving twice the clock rate.
    assign link_edge   = fwd_s ^ fwd_prev;
    assign frame_start = ready_all & ~ready_all_prev;

    always_comb begin
        next_sync1          = {lane_data, converter_ready_strobe, fwd_clk, host_shift_clk,
                               conv_start_in};
        next_sync2          = sync1;
        next_fwd_prev       = fwd_s;
        next_ready_all_prev = ready_all;
    end

    // Every flop of the block runs from the one shared clock.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1          <= '0;
            sync2          <= '0;
            fwd_prev       <= 1'b0;
            ready_all_prev <= 1'b0;
        end else begin
            sync1          <= next_sync1;
            sync2          <= next_sync2;
            fwd_prev       <= next_fwd_prev;
            ready_all_prev <= next_ready_all_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Start resync per converter, ready combine and shift clock relay.

    genvar g;
    generate
        for (g = 0; g < N_CONV; g++) begin : g_start
            logic next_start;
            always_comb begin
                next_start = start_s;
            end
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    conv_start_out[g] <= 1'b0;
                end else begin
                    conv_start_out[g] <= next_start;
                end
            end
        end
    endgenerate

    logic next_host_ready;
    logic next_conv_shift_clk;

    always_comb begin
        next_host_ready     = ready_all;
        next_conv_shift_clk = shift_s;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            host_ready     <= 1'b0;
            conv_shift_clk <= 1'b0;
        end else begin
            host_ready     <= next_host_ready;
            conv_shift_clk <= next_conv_shift_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Lane capture. A word only starts on a frame start, so bits seen before the first
    // ready rise after reset are thrown away instead of forming a misaligned sample.

    acsc_state_t              state;
    logic [`ACSC_CNT_W-1:0]   bit_cnt;
    logic [WORD_BITS-1:0]     shreg;
    acsc_state_t              next_state;
    logic [`ACSC_CNT_W-1:0]   next_bit_cnt;
    logic [WORD_BITS-1:0]     next_shreg;
    logic [WORD_BITS-1:0]     next_sample_data;
    logic                     next_sample_valid;
    logic                     next_frame_aligned;
    logic                     rx_bit;

    assign rx_bit = ~lanes_s[`ACSC_CAPTURE_LANE];

    always_comb begin
        next_state         = state;
        next_bit_cnt       = bit_cnt;
        next_shreg         = shreg;
        next_sample_data   = sample_data;
        next_sample_valid  = 1'b0;
        next_frame_aligned = frame_aligned;
        case (state)
            ACSC_WAIT: begin
                next_bit_cnt = '0;
                if (frame_start) begin
                    next_state = ACSC_SHIFT;
                    next_shreg = '0;
                end
            end
            ACSC_SHIFT: begin
                if (link_edge) begin
                    next_shreg   = {shreg[WORD_BITS-2:0], rx_bit};
                    next_bit_cnt = bit_cnt + `ACSC_CNT_W'(1);
                    if (bit_cnt == LAST_BIT) begin
                        next_sample_data   = {shreg[WORD_BITS-2:0], rx_bit};
                        next_sample_valid  = 1'b1;
                        next_frame_aligned = 1'b1;
                        next_bit_cnt       = '0;
                        next_state         = ACSC_WAIT;
                    end
                end
            end
            default: begin
                next_state = ACSC_WAIT;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state         <= ACSC_WAIT;
            bit_cnt       <= '0;
            shreg         <= '0;
            sample_data   <= '0;
            sample_valid  <= 1'b0;
            frame_aligned <= 1'b0;
        end else begin
            state         <= next_state;
            bit_cnt       <= next_bit_cnt;
            shreg         <= next_shreg;
            sample_data   <= next_sample_data;
            sample_valid  <= next_sample_valid;
            frame_aligned <= next_frame_aligned;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_frame_begin;
        (state == ACSC_WAIT) && frame_start;
    endsequence

    sequence s_last_bit;
        (state == ACSC_SHIFT) && link_edge && (bit_cnt == LAST_BIT);
    endsequence

    a_start_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(start_s) |=> (&conv_start_out))
        else $error("conversion start not passed to converters");

    a_ready_high: assert property (@(posedge mclk) disable iff (!rst_n)
        ready_all |=> host_ready)
        else $error("combined ready missing while all strobes high");

    a_ready_low: assert property (@(posedge mclk) disable iff (!rst_n)
        !(&ready_s) |=> !host_ready)
        else $error("combined ready high while a strobe is low");

    a_shift_relay: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(shift_s) |=> (conv_shift_clk == $past(shift_s)))
        else $error("shift clock not regenerated");

    a_frame_begin: assert property (@(posedge mclk) disable iff (!rst_n)
        s_frame_begin |=> (state == ACSC_SHIFT) && (bit_cnt == '0))
        else $error("capture did not start cleanly on frame start");

    a_word_done: assert property (@(posedge mclk) disable iff (!rst_n)
        s_last_bit |=> sample_valid ##1 !sample_valid)
        else $error("sample not presented after last bit");

    a_no_partial: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == ACSC_WAIT) |=> !sample_valid)
        else $error("sample presented outside a frame");

    a_data_invert: assert property (@(posedge mclk) disable iff (!rst_n)
        s_last_bit |=> (sample_data[0] == ~$past(lanes_s[`ACSC_CAPTURE_LANE])))
        else $error("recovered bit not inverted");

    a_both_edges: assert property (@(posedge mclk) disable iff (!rst_n)
        ((state == ACSC_SHIFT) && link_edge && (bit_cnt != LAST_BIT))
            |=> (bit_cnt == $past(bit_cnt) + `ACSC_CNT_W'(1)))
        else $error("forwarded clock edge did not take a bit");

    a_hold_no_edge: assert property (@(posedge mclk) disable iff (!rst_n)
        ((state == ACSC_SHIFT) && !link_edge) |=> $stable(bit_cnt) && $stable(shreg))
        else $error("bit taken without a forwarded clock edge");

endmodule : acsc_capture
`default_nettype wire

//--- design/acsc_params.svh
// Constants for the converter serial capture block.
`ifndef ACSC_PARAMS_SVH
`define ACSC_PARAMS_SVH
`define ACSC_SYS_CLK_HZ      65000000
`define ACSC_SER_BITS_CYCLE  7
`define ACSC_DESER_MULT_X2   7
`define ACSC_N_CONV          2
`define ACSC_LANES           4
`define ACSC_WORD_BITS       18
`define ACSC_CNT_W           5
`define ACSC_SYNC_START      0
`define ACSC_SYNC_SHIFT      1
`define ACSC_SYNC_FWD        2
`define ACSC_SYNC_READY      3
`define ACSC_CAPTURE_LANE    0
`endif

//--- design/acsc_pkg.sv
// Types for the converter serial capture block.
`default_nettype none
package acsc_pkg;
    typedef enum logic [0:0] {
        ACSC_WAIT  = 1'b0,
        ACSC_SHIFT = 1'b1
    } acsc_state_t;
endpackage : acsc_pkg
`default_nettype wire

//--- dv/acsc_capture_tb.sv
// Self-checking bench for the converter serial capture block.
`timescale 1ns/1ps
`default_nettype none
module acsc_capture_tb;
    logic        mclk = 1'b0, rst_n = 1'b0, conv_start_in = 1'b0, host_shift_clk = 1'b0;
    logic        send = 1'b0, chk_en = 1'b0;
    logic [17:0] word = 18'h0_0000, sample_data;
    logic [2:0]  h0, h1, h2;
    logic [1:0]  ready, conv_start_out;
    logic [3:0]  lane_data;
    logic        fwd_clk, conv_shift_clk, host_ready, sample_valid, frame_aligned;
    int          miscompares = 0, tests_run = 0, cycles = 0;
    ////////////////////////////////////////
    acsc_capture dut (.mclk(mclk), .rst_n(rst_n), .conv_start_in(conv_start_in),
        .converter_ready_strobe(ready), .host_shift_clk(host_shift_clk),
        .fwd_clk(fwd_clk), .lane_data(lane_data), .conv_start_out(conv_start_out),
        .host_ready(host_ready), .conv_shift_clk(conv_shift_clk),
        .sample_data(sample_data), .sample_valid(sample_valid),
        .frame_aligned(frame_aligned));
    acsc_conv_model model (.mclk(mclk), .send(send), .word(word),
        .conv_shift_clk(conv_shift_clk), .converter_ready_strobe(ready),
        .fwd_clk(fwd_clk), .lane_data(lane_data));
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        conv_start_in <= #1 1'($urandom);
        cycles++;
        // Eight words need about a hundred cycles each; the ceiling leaves ample margin.
        if (cycles == 6000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic check(input string nm, input logic [17:0] exp, input logic [17:0] seen);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    always @(negedge mclk) begin
        if (chk_en) begin
            check("start", 18'({2{h2[2]}}), 18'(conv_start_out));
            check("ready", 18'(h2[1]), 18'(host_ready));
            check("shift", 18'(h2[0]), 18'(conv_shift_clk));
        end
        h2 = h1;
        h1 = h0;
        h0 = {conv_start_in, &ready, host_shift_clk};
    end
    task automatic do_reset();
        chk_en = 1'b0;
        @(posedge mclk) #1 rst_n = 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check("rst data", 18'h0_0000, sample_data);
        check("rst flags", 18'h0_0000, 18'({conv_start_out, host_ready, conv_shift_clk,
            sample_valid, frame_aligned}));
        @(posedge mclk) #1 rst_n = 1'b1;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        // No word may be claimed before the first full frame after reset.
        check("unaligned", 18'h0_0000, 18'({sample_valid, frame_aligned}));
        chk_en = 1'b1;
        $display("test reset done");
    endtask : do_reset
    task automatic send_word(input logic [17:0] w);
        int n, m;
        @(posedge mclk) #1 word = w;
        send = 1'b1;
        @(posedge mclk) #1 send = 1'b0;
        fork
            begin
                n = 0;
                while (host_ready !== 1'b1 && n < 100) begin
                    @(posedge mclk) #1 n++;
                end
                repeat (44) begin
                    @(posedge mclk) #1 host_shift_clk = ~host_shift_clk;
                end
            end
            begin
                m = 0;
                while (sample_valid !== 1'b1 && m < 300) begin
                    @(negedge mclk) m++;
                end
                check("valid", 18'h0_0001, 18'(sample_valid));
                check("data", w, sample_data);
                check("aligned", 18'h0_0001, 18'(frame_aligned));
                @(negedge mclk);
                check("pulse", 18'h0_0000, 18'(sample_valid));
            end
        join
    endtask : send_word
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    initial begin
        void'($urandom(32'h484a_d4d1));
        do_reset();
        for (int i = 0; i < 8; i++) begin
            if (i == 5)
                do_reset();
            send_word(i == 0 ? 18'h0_0000 : i == 1 ? 18'h3_ffff : i == 2 ? 18'h2_0001
                : 18'($urandom));
            $display("test word %0d done", i);
        end
        end_of_test();
    end
endmodule : acsc_capture_tb
`default_nettype wire

//--- dv/acsc_conv_model.sv
// Behavioural converter pair with serializer, as seen from the capture pins.
`timescale 1ns/1ps
`default_nettype none
module acsc_conv_model (
    input  wire logic        mclk,
    input  wire logic        send,
    input  wire logic [17:0] word,
    input  wire logic        conv_shift_clk,
    output logic      [1:0]  converter_ready_strobe,
    output logic             fwd_clk,
    output logic      [3:0]  lane_data
);
    ////////////////////////////////////////
    int n;
    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : step
    initial begin
        converter_ready_strobe = 2'b00;
        fwd_clk = 1'b0;
        lane_data = 4'h0;
        forever begin
            @(posedge mclk);
            if (send) begin
                // Idle lanes keep changing, so a stale bit can never pass as data.
                repeat (4) begin
                    step(4);
                    lane_data = ~lane_data;
                    fwd_clk = ~fwd_clk;
                end
                converter_ready_strobe[0] = 1'b1;
                step(3);
                converter_ready_strobe[1] = 1'b1;
                n = 0;
                while (conv_shift_clk !== 1'b1 && n < 60) begin
                    step(1);
                    n++;
                end
                for (int i = 17; i >= 0; i--) begin
                    lane_data = {~lane_data[3:1], ~word[i]};
                    step(2);
                    fwd_clk = ~fwd_clk;
                    step(2);
                end
                converter_ready_strobe = 2'b00;
            end else begin
                #1;
                lane_data = ~lane_data;
            end
        end
    end
endmodule : acsc_conv_model
`default_nettype wire
